// ---- design/bol_loader.sv ----
// Purpose: fetches the boot configuration byte and applies it
// Assumes: flash answers with a one-cycle ack; plain APB master
// Notes:   settle counts are parameters so a bench can shorten them
//
// Overview of operation
// - fetch byte at 0x0080 after every reset
// - fixed bit layout; bits 7, 4 one
// - settle code selects 2^10/12/15/17 periods
// - settle wait only for crystal oscillator
// - keep bit one keeps reset pin
// - low reset pin before fetch holds reset
// - code 00 crystal, 01 external, 1x internal
// - crystal uses both oscillator pins
// - external frees pin two; internal frees both
// - lock bit blocks software stop of oscillator
// - lock forces watchdog onto slow oscillator
// - unlocked watchdog clock gated in halt, stop
// - running slow oscillator feeds timer in stop
// - port-mode reset pin needs programmer first

`timescale 1ns/1ps
`default_nettype none

module bol_loader
	import bol_pkg::*;
#(
	parameter logic [SETTLE_W-1:0] SETTLE_CNT0 = SETTLE_W'(1 << SETTLE_EXP0),
	parameter logic [SETTLE_W-1:0] SETTLE_CNT1 = SETTLE_W'(1 << SETTLE_EXP1),
	parameter logic [SETTLE_W-1:0] SETTLE_CNT2 = SETTLE_W'(1 << SETTLE_EXP2),
	parameter logic [SETTLE_W-1:0] SETTLE_CNT3 = SETTLE_W'(1 << SETTLE_EXP3)
) (
	input  wire logic        clock,
	input  wire logic        sys_rst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	// flash read port
	output var  logic        flash_req,
	output var  logic [15:0] flash_addr,
	input  wire logic        flash_ack,
	input  wire logic [7:0]  flash_rdata,
	// pins
	input  wire logic        reset_pin_n,
	input  wire logic        osc_in_pin,
	// cpu power modes, same clock domain
	input  wire logic        halt_mode,
	input  wire logic        stop_mode,
	// applied configuration
	output var  logic        core_reset,
	output var  logic        reset_alt_input_pin,
	output var  logic        reset_pin_is_port,
	output var  logic [1:0]  clk_src,
	output var  logic        osc_in_is_clock,
	output var  logic        osc_out_is_clock,
	output var  logic        osc_in_port_pin_en,
	output var  logic        osc_out_port_pin_en,
	output var  logic        slow_osc_run,
	output var  logic        wdt_clk_en,
	output var  logic        wdt_clk_slow,
	output var  logic        timer8_clk_en
);

	// ==========================================================
	// declarations
	// ==========================================================
	bol_state_e          state;             // boot sequencer
	bol_state_e          next_state;        // its next value
	logic [7:0]          cfg;               // latched configuration byte
	logic                fmt_err;           // fixed bits were not both one
	logic                slow_osc_stop;     // software stop request
	logic                wdt_src_slow;      // software watchdog count clock choice
	logic                pin_sync;          // filtered reset pin level
	logic                osc_sync;          // filtered oscillator pin level
	logic                osc_prev;          // for rising edge detection
	logic                settle_done;       // settle counter reached target
	logic [SETTLE_W-1:0] settle_target;     // chosen settle count

	// ==========================================================
	// pin synchronisers
	// ==========================================================
	// reset pin reads low until the filter has really sampled it, so a
	// pin held low through reset release never lets the fetch start
	bol_sync3 #(
		.RST_VAL  (1'b0)
	) u_sync_rst_pin (
		.clock    (clock),
		.sys_rst  (sys_rst),
		.async_in (reset_pin_n),
		.sync_out (pin_sync)
	);

	// oscillator pin, counted for the settle wait
	bol_sync3 #(
		.RST_VAL  (1'b0)
	) u_sync_osc (
		.clock    (clock),
		.sys_rst  (sys_rst),
		.async_in (osc_in_pin),
		.sync_out (osc_sync)
	);

	// edge history for the oscillator count
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			osc_prev <= 1'b0;
		end else begin
			osc_prev <= osc_sync;
		end
	end

	wire osc_rise = osc_sync && !osc_prev;   // one pulse per oscillator period

	// ==========================================================
	// configuration field decode
	// ==========================================================
	wire [1:0] settle_code = {cfg[CFG_SETTLE_HI], cfg[CFG_SETTLE_LO]};
	wire       rst_keep    = cfg[CFG_RST_KEEP_BIT];
	wire [1:0] src_code    = {cfg[CFG_CLK_HI], cfg[CFG_CLK_LO]};
	wire       osc_lock    = cfg[CFG_LOCK_BIT];
	wire       fetched_bad = !(flash_rdata[CFG_FIXED_HI_BIT] && flash_rdata[CFG_FIXED_LO_BIT]);

	// internal oscillator whenever the upper bit is set
	wire       src_int  = src_code[1];
	wire       src_xtal = (src_code == CLK_SRC_XTAL);
	wire       src_ext  = (src_code == CLK_SRC_EXT);

	// fetched byte is the one about to be applied at settle decision
	wire [1:0] new_src  = {flash_rdata[CFG_CLK_HI], flash_rdata[CFG_CLK_LO]};
	wire       new_xtal = (new_src == CLK_SRC_XTAL);

	// settle count table; wide counts are parameters, not constants
	assign settle_target = (settle_code == 2'h0) ? SETTLE_CNT0 :
	                       (settle_code == 2'h1) ? SETTLE_CNT1 :
	                       (settle_code == 2'h2) ? SETTLE_CNT2 :
	                                               SETTLE_CNT3;

	// counter only runs while waiting for the crystal to settle
	bol_settle_cnt u_settle (
		.clock     (clock),
		.sys_rst   (sys_rst),
		.run       (state == ST_SETTLE),
		.edge_seen (osc_rise),
		.target    (settle_target),
		.done      (settle_done)
	);

	// ==========================================================
	// boot sequencer
	// ==========================================================
	// the pin acts as a reset until the run state, whatever the stored
	// byte says; in the run state it is a reset only if kept
	wire pin_resets = !pin_sync && ((state != ST_RUN) || rst_keep);

	always_comb begin
		next_state = state;
		unique case (state)
			// wait for the pin to release before the byte can be read
			ST_HOLD: begin
				if (pin_sync) begin
					next_state = ST_FETCH;
				end
			end
			// byte read; crystal needs a settle wait, others go straight on
			ST_FETCH: begin
				if (!pin_sync) begin
					next_state = ST_HOLD;
				end else if (flash_ack) begin
					next_state = new_xtal ? ST_SETTLE : ST_RUN;
				end
			end
			// count oscillator periods
			ST_SETTLE: begin
				if (!pin_sync) begin
					next_state = ST_HOLD;
				end else if (settle_done) begin
					next_state = ST_RUN;
				end
			end
			// normal operation; a kept reset pin restarts the boot
			ST_RUN: begin
				if (pin_resets) begin
					next_state = ST_HOLD;
				end
			end
		endcase
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state <= ST_HOLD;
		end else begin
			state <= next_state;
		end
	end

	// ==========================================================
	// configuration latch
	// ==========================================================
	// loaded once per boot; later flash changes are not seen
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cfg     <= CFG_RESET_VAL;
			fmt_err <= 1'b0;
		end else if (state == ST_FETCH && flash_ack) begin
			cfg     <= flash_rdata;
			fmt_err <= fetched_bad;
		end
	end

	// flash request held through the fetch state only
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			flash_req  <= 1'b0;
			flash_addr <= CFG_FLASH_ADDR;
		end else begin
			flash_req  <= (next_state == ST_FETCH) && !(state == ST_FETCH && flash_ack);
			flash_addr <= CFG_FLASH_ADDR;
		end
	end

	// ==========================================================
	// apb slave decode
	// ==========================================================
	wire acc      = psel && penable && !pready;    // access phase, first cycle
	wire wr_done  = psel && penable && pready && pwrite;
	wire hit_cfg  = (paddr == OFS_CONFIG);
	wire hit_st   = (paddr == OFS_STATUS);
	wire hit_slow = (paddr == OFS_SLOW_OSC);
	wire hit_wdt  = (paddr == OFS_WDT_CTRL);
	wire hit_any  = hit_cfg || hit_st || hit_slow || hit_wdt;

	// status word: the block's own state
	wire [31:0] st_word = {27'h000_0000, wdt_clk_en, slow_osc_run, fmt_err, state};

	wire [31:0] rd_mux  = hit_cfg  ? {24'h00_0000, cfg} :
	                      hit_st   ? st_word :
	                      hit_slow ? {31'h0000_0000, slow_osc_stop} :
	                      hit_wdt  ? {31'h0000_0000, wdt_src_slow} :
	                                 32'h0000_0000;

	// one wait state; read data and error valid with pready
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= acc;
			pslverr <= acc && !hit_any;
			prdata  <= (acc && !pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	// software control registers; writes land with pready
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			slow_osc_stop <= SLOW_STOP_RST;
			wdt_src_slow  <= WDT_SLOW_RST;
		end else if (wr_done) begin
			if (hit_slow) begin
				slow_osc_stop <= pwdata[SLOW_STOP_BIT];
			end
			if (hit_wdt) begin
				wdt_src_slow <= pwdata[WDT_SLOW_BIT];
			end
		end
	end

	// ==========================================================
	// applied functions, next values
	// ==========================================================
	// stop request has no effect while locked
	wire next_slow_run  = osc_lock || !slow_osc_stop;
	// locked: forced to slow clock; unlocked: gated in halt and stop,
	// and when another count clock is chosen
	wire next_wdt_slow  = osc_lock || wdt_src_slow;
	wire next_wdt_en    = osc_lock ? 1'b1 :
	                      (wdt_src_slow && next_slow_run && !halt_mode && !stop_mode);
	// timer keeps its clock in stop mode while oscillator runs
	wire next_timer_en  = next_slow_run;
	// pin roles: crystal takes both, external takes pin one only
	wire next_in_clk    = src_xtal || src_ext;
	wire next_out_clk   = src_xtal;
	wire next_in_port   = src_int;
	wire next_out_port  = !src_xtal;
	// pin becomes a port only once the byte is applied; before that
	// a programmer can still reach reset, hence power-up order matters
	wire next_is_port   = (state == ST_RUN) && !rst_keep;

	// ==========================================================
	// output registers
	// ==========================================================
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			core_reset          <= 1'b1;
			reset_alt_input_pin <= 1'b1;
			reset_pin_is_port   <= 1'b0;
			clk_src             <= CLK_SRC_XTAL;
			osc_in_is_clock     <= 1'b0;
			osc_out_is_clock    <= 1'b0;
			osc_in_port_pin_en  <= 1'b0;
			osc_out_port_pin_en <= 1'b0;
			slow_osc_run        <= 1'b1;
			wdt_clk_en          <= 1'b0;
			wdt_clk_slow        <= 1'b1;
			timer8_clk_en       <= 1'b0;
		end else begin
			core_reset          <= (next_state != ST_RUN);
			reset_alt_input_pin <= next_is_port ? pin_sync : 1'b1;
			reset_pin_is_port   <= next_is_port;
			clk_src             <= src_code;
			osc_in_is_clock     <= next_in_clk;
			osc_out_is_clock    <= next_out_clk;
			osc_in_port_pin_en  <= next_in_port;
			osc_out_port_pin_en <= next_out_port;
			slow_osc_run        <= next_slow_run;
			wdt_clk_en          <= next_wdt_en && (state == ST_RUN);
			wdt_clk_slow        <= next_wdt_slow;
			timer8_clk_en       <= next_timer_en;
		end
	end

endmodule : bol_loader

`default_nettype wire

// ---- design/bol_pkg.sv ----
// Purpose: shared constants for the boot configuration byte loader
// Assumes: one 250 MHz clock, APB register access with 32-bit data
// Notes:   counts of oscillator periods above 4096 live as top parameters

package bol_pkg;

	// ==========================================================
	// flash location of the boot configuration byte
	// ==========================================================
	localparam logic [15:0] CFG_FLASH_ADDR   = 16'h0080;

	// ==========================================================
	// boot configuration byte field layout
	// ==========================================================
	localparam int          CFG_FIXED_HI_BIT = 7;   // must read 1
	localparam int          CFG_SETTLE_HI    = 6;   // settle_time_sel_hi
	localparam int          CFG_SETTLE_LO    = 5;   // settle_time_sel_lo
	localparam int          CFG_FIXED_LO_BIT = 4;   // must read 1
	localparam int          CFG_RST_KEEP_BIT = 3;   // reset_pin_keep
	localparam int          CFG_CLK_HI       = 2;   // clk_src_sel_hi
	localparam int          CFG_CLK_LO       = 1;   // clk_src_sel_lo
	localparam int          CFG_LOCK_BIT     = 0;   // slow_osc_lock
	localparam logic [7:0]  CFG_RESET_VAL    = 8'hff;

	// ==========================================================
	// clock source codes
	// ==========================================================
	localparam logic [1:0]  CLK_SRC_XTAL     = 2'h0;
	localparam logic [1:0]  CLK_SRC_EXT      = 2'h1;

	// ==========================================================
	// settle exponents, in input oscillator periods (2^n)
	// ==========================================================
	localparam int          SETTLE_EXP0      = 10;
	localparam int          SETTLE_EXP1      = 12;
	localparam int          SETTLE_EXP2      = 15;
	localparam int          SETTLE_EXP3      = 17;
	localparam int          SETTLE_W         = 18;

	// ==========================================================
	// register byte offsets
	// ==========================================================
	localparam logic [11:0] OFS_CONFIG       = 12'h000;
	localparam logic [11:0] OFS_STATUS       = 12'h004;
	localparam logic [11:0] OFS_SLOW_OSC     = 12'h008;
	localparam logic [11:0] OFS_WDT_CTRL     = 12'h00c;

	// ==========================================================
	// register fields and reset values
	// ==========================================================
	localparam int          SLOW_STOP_BIT    = 0;
	localparam int          WDT_SLOW_BIT     = 0;
	localparam logic        SLOW_STOP_RST    = 1'b0;
	localparam logic        WDT_SLOW_RST     = 1'b1;
	localparam int          ST_STATE_LO      = 0;   // status: sequencer state, 2 bits
	localparam int          ST_FMT_ERR_BIT   = 2;
	localparam int          ST_SLOW_RUN_BIT  = 3;
	localparam int          ST_WDT_EN_BIT    = 4;

	// ==========================================================
	// boot sequencer states, gray along the path
	// ==========================================================
	typedef enum logic [1:0] {
		ST_HOLD   = 2'b00,
		ST_FETCH  = 2'b01,
		ST_SETTLE = 2'b11,
		ST_RUN    = 2'b10
	} bol_state_e;

endpackage : bol_pkg

// ---- design/bol_sync3.sv ----
// Purpose: three-stage synchroniser with agreement filter for pin inputs
// Assumes: input is asynchronous to clock
// Notes:   the output moves only when stages two and three agree

`timescale 1ns/1ps
`default_nettype none

module bol_sync3 #(
	parameter logic RST_VAL = 1'b0
) (
	input  wire logic clock,
	input  wire logic sys_rst,
	input  wire logic async_in,
	output var  logic sync_out
);

	logic meta;   // first stage, read only by stage two
	logic s2;     // second stage
	logic s3;     // third stage

	// ==========================================================
	// shift chain
	// ==========================================================
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			meta <= RST_VAL;
			s2   <= RST_VAL;
			s3   <= RST_VAL;
		end else begin
			meta <= async_in;
			s2   <= meta;
			s3   <= s2;
		end
	end

	// agreement: a one-cycle glitch never reaches the output
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			sync_out <= RST_VAL;
		end else if (s2 == s3) begin
			sync_out <= s3;
		end
	end

endmodule : bol_sync3

`default_nettype wire

// ---- design/bol_settle_cnt.sv ----
// Purpose: counts oscillator rising edges up to a target
// Assumes: edge strobe is already synchronised to clock
// Notes:   clears whenever run drops, so each boot starts from zero

`timescale 1ns/1ps
`default_nettype none

module bol_settle_cnt
	import bol_pkg::*;
(
	input  wire logic                clock,
	input  wire logic                sys_rst,
	input  wire logic                run,
	input  wire logic                edge_seen,
	input  wire logic [SETTLE_W-1:0] target,
	output var  logic                done
);

	logic [SETTLE_W-1:0] count;   // edges seen so far
	wire                 at_goal = (count >= target);

	// ==========================================================
	// edge counter
	// ==========================================================
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			count <= '0;
			done  <= 1'b0;
		end else if (!run) begin
			count <= '0;
			done  <= 1'b0;
		end else begin
			if (edge_seen && !at_goal) begin
				count <= count + 1'b1;
			end
			done <= at_goal;
		end
	end

endmodule : bol_settle_cnt

`default_nettype wire

// ---- test/bol_loader_properties.sv ----
// Purpose: port-level checker for bol_loader
// Assumes: one clock, outputs lag latched byte by one clock
// Notes:   bound to every loader instance
`timescale 1ns/1ps
`default_nettype none
module bol_loader_chk (
	input wire logic        clock,
	input wire logic        sys_rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        flash_req,
	input wire logic        flash_ack,
	input wire logic [7:0]  flash_rdata,
	input wire logic [15:0] flash_addr,
	input wire logic        core_reset,
	input wire logic        reset_pin_is_port,
	input wire logic [1:0]  clk_src,
	input wire logic        osc_in_is_clock,
	input wire logic        osc_out_is_clock,
	input wire logic        osc_in_port_pin_en,
	input wire logic        osc_out_port_pin_en,
	input wire logic        slow_osc_run,
	input wire logic        wdt_clk_en,
	input wire logic        timer8_clk_en
);
	// ==========================================================
	// clocking and helpers
	// ==========================================================
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	wire logic       take   = flash_req && flash_ack;  // byte handed over
	wire logic [1:0] rd_src = flash_rdata[2:1];        // fetched clock code
	wire logic [3:0] pins   = {osc_in_is_clock, osc_out_is_clock, osc_in_port_pin_en, osc_out_port_pin_en};
	// ==========================================================
	// assertions
	// ==========================================================
	AST_FLASH_ADDR: assert property (flash_addr == 16'h0080)
		else $error("flash address wrong");
	AST_HELD_FETCH: assert property (flash_req |-> core_reset)
		else $error("core ran during fetch");
	AST_REQ_DROP: assert property (take |=> !flash_req)
		else $error("fetch request stayed up");
	AST_CLK_SRC: assert property (take |=> ##1 clk_src == $past(rd_src, 2))
		else $error("clock source not applied");
	AST_NO_WAIT: assert property (take && rd_src != 2'h0 |-> ##[1:3] !core_reset)
		else $error("settle wait without crystal");
	AST_SETTLE: assert property (take && rd_src == 2'h0 |=> core_reset [*4])
		else $error("crystal settle wait skipped");
	// stale pins after release are masked by two quiet cycles
	AST_XTAL: assert property ((!core_reset [*2]) ##0 clk_src == 2'h0 |-> pins == 4'hc)
		else $error("crystal pin use wrong");
	AST_EXT: assert property ((!core_reset [*2]) ##0 clk_src == 2'h1 |-> pins == 4'h9)
		else $error("external clock pin use wrong");
	AST_INT: assert property ((!core_reset [*2]) ##0 clk_src[1] |-> pins == 4'h3)
		else $error("internal clock pin use wrong");
	AST_STOP_GATE: assert property (!slow_osc_run |-> !wdt_clk_en && !timer8_clk_en)
		else $error("clock passed while stopped");
	AST_PORT: assert property (reset_pin_is_port |-> !core_reset)
		else $error("port mode while in reset");
	AST_APB_WAIT: assert property (psel && penable && !pready |=> pready)
		else $error("apb answer late");
	AST_APB_ERR: assert property (pslverr |-> pready && psel && penable)
		else $error("error outside access");
endmodule : bol_loader_chk
bind bol_loader bol_loader_chk CHK (.clock, .sys_rst, .psel, .penable, .pready, .pslverr, .flash_req,
	.flash_ack, .flash_rdata, .flash_addr, .core_reset, .reset_pin_is_port, .clk_src, .osc_in_is_clock,
	.osc_out_is_clock, .osc_in_port_pin_en, .osc_out_port_pin_en, .slow_osc_run, .wdt_clk_en, .timer8_clk_en);
`default_nettype wire

// ---- test/tb_top.sv ----
// Purpose: self-checking bench for bol_loader
// Assumes: settle counts cut to 4/6/8/10 oscillator edges
// Notes:   oscillator pin toggles every 4 clocks
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import bol_pkg::*;
	logic        clock, sys_rst, psel, penable, pwrite, flash_ack, reset_pin_n, osc_in_pin;
	logic        halt_mode, stop_mode, pready, pslverr, flash_req, core_reset, reset_alt_input_pin;
	logic        reset_pin_is_port, osc_in_is_clock, osc_out_is_clock, osc_in_port_pin_en;
	logic        osc_out_port_pin_en, slow_osc_run, wdt_clk_en, wdt_clk_slow, timer8_clk_en, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] flash_addr;
	logic [7:0]  flash_rdata, cfg;
	logic [1:0]  clk_src;
	int          mismatches, tests_run, n;
	bol_loader #(.SETTLE_CNT0(18'h4), .SETTLE_CNT1(18'h6), .SETTLE_CNT2(18'h8), .SETTLE_CNT3(18'ha)) DUT (
		.clock, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.flash_req, .flash_addr, .flash_ack, .flash_rdata, .reset_pin_n, .osc_in_pin, .halt_mode,
		.stop_mode, .core_reset, .reset_alt_input_pin, .reset_pin_is_port, .clk_src, .osc_in_is_clock,
		.osc_out_is_clock, .osc_in_port_pin_en, .osc_out_port_pin_en, .slow_osc_run, .wdt_clk_en,
		.wdt_clk_slow, .timer8_clk_en);
	// ==========================================================
	// clock and slow oscillator pin
	// ==========================================================
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	// well below clock/4 so the filter passes every edge
	always begin
		repeat (4) @(posedge clock);
		osc_in_pin <= ~osc_in_pin;
	end
	// ==========================================================
	// report, compare and bus tasks
	// ==========================================================
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : test_done
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic hang;
		mismatches++;
		$display("BAD %0t wait ran out", $time);
		test_done;
	endtask : hang
	// entered just after a rising edge; holds until pready is sampled
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) hang;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// idle edge so the next setup never reassigns psel in this step
		@(posedge clock);
	endtask : apb
	// xtal: 4'hc, external: 4'h9, internal: 4'h3
	function automatic logic [3:0] pin_use(input logic [1:0] s);
		return s[1] ? 4'h3 : (s[0] ? 4'h9 : 4'hc);
	endfunction : pin_use
	task automatic boot(input logic [7:0] b);
		int k;
		int e;
		k = 0;
		e = 4 + 2 * b[6:5];
		while (flash_req !== 1'b1 && k < 50) begin
			@(posedge clock);
			k++;
		end
		if (k >= 50) hang;
		chk(flash_addr, 32'h0000_0080);
		flash_rdata <= b;
		flash_ack <= 1'b1;
		@(posedge clock);
		flash_ack <= 1'b0;
		flash_rdata <= ~b;
		k = 0;
		while (core_reset !== 1'b0 && k < 200) begin
			@(posedge clock);
			k++;
		end
		if (k >= 200) hang;
		if (b[2:1] == 2'h0) chk(k >= (e - 1) * 8 && k <= e * 8 + 12, 1);
		else chk(k <= 3, 1);
		repeat (2) @(posedge clock);
	endtask : boot
	// ==========================================================
	// main sequence
	// ==========================================================
	initial begin
		{psel, penable, pwrite, flash_ack, halt_mode, stop_mode, osc_in_pin} = '0;
		{paddr, pwdata, flash_rdata, mismatches, tests_run} = '0;
		reset_pin_n = 1'b1;
		sys_rst = 1'b1;
		n = $urandom(32'h0000_e97d);
		repeat (2) @(posedge clock);
		for (int i = 0; i < 10; i++) begin
			cfg = 8'($urandom);
			if (i < 4) {cfg[6:5], cfg[2:1]} = {i[1:0], 2'h0};
			else if (i < 8) cfg[2:1] = i[1:0];
			// last boot leaves bit 4 clear to reach the format flag
			{cfg[7], cfg[4]} = (i == 9) ? 2'h2 : 2'h3;
			reset_pin_n <= 1'b0;
			sys_rst <= 1'b0;
			repeat (8) @(posedge clock);
			chk({flash_req, core_reset}, 2'b01);
			reset_pin_n <= 1'b1;
			boot(cfg);
			chk({osc_in_is_clock, osc_out_is_clock, osc_in_port_pin_en, osc_out_port_pin_en}, pin_use(cfg[2:1]));
			chk(clk_src, cfg[2:1]);
			chk(reset_pin_is_port, !cfg[3]);
			apb(1'b0, 12'h008, 32'h0);
			chk(rd, 32'h0);
			apb(1'b0, 12'h00c, 32'h0);
			chk(rd, 32'h1);
			apb(1'b0, 12'h004, 32'h0);
			chk(rd, {27'h000_0000, 2'h3, !(cfg[7] & cfg[4]), 2'h2});
			apb(1'b1, 12'h000, 32'h0);
			apb(1'b1, 12'h010, 32'h1);
			chk(err, 1);
			apb(1'b0, 12'h000, 32'h0);
			chk(rd, cfg);
			apb(1'b1, 12'h008, 32'h1);
			apb(1'b1, 12'h00c, 32'h0);
			repeat (2) @(posedge clock);
			chk({slow_osc_run, timer8_clk_en, wdt_clk_slow, wdt_clk_en}, {4{cfg[0]}});
			apb(1'b1, 12'h008, 32'h0);
			apb(1'b1, 12'h00c, 32'h1);
			halt_mode <= 1'($urandom);
			stop_mode <= 1'($urandom);
			repeat (3) @(posedge clock);
			chk({wdt_clk_en, timer8_clk_en}, {cfg[0] | !(halt_mode | stop_mode), 1'b1});
			{halt_mode, stop_mode} <= 2'h0;
			reset_pin_n <= 1'b0;
			repeat (8) @(posedge clock);
			chk({core_reset, reset_alt_input_pin}, {2{cfg[3]}});
			reset_pin_n <= 1'b1;
			sys_rst <= 1'b1;
			@(posedge clock);
			$display("boot %0d byte %h finished", i, cfg);
		end
		test_done;
	end
endmodule : tb_top
`default_nettype wire
